// ---- include/paper_feed_pkg.sv ----
// Shared types and constants for the paper pickup and feed sequencer
package paper_feed_pkg;

	// Print modes from the formatter
	typedef enum logic [3:0] {
		MODE_AUTO      = 4'h0,
		MODE_NORMAL    = 4'h1,
		MODE_HEAVY1    = 4'h2,
		MODE_HEAVY2    = 4'h3,
		MODE_HEAVY3    = 4'h4,
		MODE_GLOSSY1   = 4'h5,
		MODE_GLOSSY2   = 4'h6,
		MODE_GLOSSY3   = 4'h7,
		MODE_GLOSSFILM = 4'h8,
		MODE_TRANSP    = 4'h9,
		MODE_LIGHT     = 4'hA,
		MODE_ENVELOPE  = 4'hB,
		MODE_LABEL     = 4'hC
	} print_mode_t;

	// Sensed media classes
	typedef enum logic [2:0] {
		MEDIA_PLAIN     = 3'h0,
		MEDIA_HEAVY1    = 3'h1,
		MEDIA_HEAVY2    = 3'h2,
		MEDIA_HEAVY3    = 3'h3,
		MEDIA_GLOSSY    = 3'h4,
		MEDIA_FILM      = 3'h5,
		MEDIA_TRANSP    = 3'h6,
		MEDIA_UNKNOWN   = 3'h7
	} media_t;

	// Feed speed settings
	typedef enum logic [2:0] {
		SPEED_FULL  = 3'h0,
		SPEED_3Q    = 3'h1,
		SPEED_HALF  = 3'h2,
		SPEED_THIRD = 3'h3,
		SPEED_TENTH = 3'h4
	} speed_t;

	// Sequencer states, one-hot
	typedef enum logic [8:0] {
		ST_IDLE     = 9'h001,
		ST_WAITPAP  = 9'h002,
		ST_REVERSE  = 9'h004,
		ST_PICK     = 9'h008,
		ST_FEED     = 9'h010,
		ST_PAUSE    = 9'h020,
		ST_RUN      = 9'h040,
		ST_SELFTEST = 9'h080,
		ST_TESTWAIT = 9'h100
	} seq_state_t;

	// Timing, 100 MHz clock
	localparam int CLK_MHZ          = 100;
	localparam int REVERSE_US       = 50;
	localparam int REVERSE_CYC      = REVERSE_US * CLK_MHZ;
	localparam int SENSE_SETTLE_US  = 10;
	localparam int SENSE_SETTLE_CYC = SENSE_SETTLE_US * CLK_MHZ;
	localparam int CNT_W            = 16;

	// Media sensor thresholds
	localparam logic [7:0] GLOSS_HIGH    = 8'hC0;
	localparam logic [7:0] GLOSS_MID     = 8'h80;
	localparam logic [7:0] TRANS_CLEAR   = 8'hE0;
	localparam logic [7:0] TRANS_HEAVY1  = 8'h90;
	localparam logic [7:0] TRANS_HEAVY2  = 8'h60;
	localparam logic [7:0] TRANS_HEAVY3  = 8'h30;
	localparam logic [7:0] LED_EXPECT    = 8'hA0;
	localparam logic [7:0] LED_TOL       = 8'h10;

	// Job request from the formatter
	typedef struct packed {
		print_mode_t mode;
		logic        duplex;
	} job_t;

	// Notifications to the formatter
	typedef struct packed {
		logic   trayEmpty;
		logic   lastSheet;
		logic   binFull;
		logic   mismatch;
		logic   sensorFail;
		logic   typeValid;
		media_t mediaType;
	} notify_t;

	// Motor and solenoid drives
	typedef struct packed {
		logic   pickupRev;
		logic   pickupSol;
		logic   regMotor;
		logic   mediaLed;
		speed_t speed;
	} drive_t;

endpackage

// ---- hw/media_classifier.sv ----
// Media classification and feed speed selection
`timescale 1ns/1ps
module media_classifier
	import paper_feed_pkg::*;
(
	// Sensor readings
	input  wire logic [7:0] reflect,
	input  wire logic [7:0] transmit,
	// Job
	input  wire job_t       job,
	// Results
	output media_t          media,
	output speed_t          speed,
	output logic            mismatch
);

	always_comb begin
		if (reflect >= GLOSS_HIGH && transmit >= TRANS_CLEAR)
			media = MEDIA_TRANSP;
		else if (reflect >= GLOSS_HIGH)
			media = MEDIA_FILM;
		else if (reflect >= GLOSS_MID)
			media = MEDIA_GLOSSY;
		else if (transmit >= TRANS_HEAVY1)
			media = MEDIA_PLAIN;
		else if (transmit >= TRANS_HEAVY2)
			media = MEDIA_HEAVY1;
		else if (transmit >= TRANS_HEAVY3)
			media = MEDIA_HEAVY2;
		else
			media = MEDIA_HEAVY3;
	end

	// Speed follows job mode; sensor-blind modes use the mode directly
	always_comb begin
		case (job.mode)
			MODE_HEAVY1, MODE_GLOSSY1:  speed = SPEED_3Q;
			MODE_HEAVY2, MODE_GLOSSY2:  speed = SPEED_HALF;
			MODE_HEAVY3, MODE_GLOSSY3:  speed = SPEED_THIRD;
			MODE_GLOSSFILM, MODE_TRANSP: speed = SPEED_TENTH;
			MODE_LIGHT, MODE_ENVELOPE:  speed = SPEED_FULL;
			MODE_LABEL:                 speed = SPEED_HALF;
			MODE_AUTO: begin
				case (media)
					MEDIA_HEAVY1, MEDIA_GLOSSY: speed = SPEED_3Q;
					MEDIA_HEAVY2:               speed = SPEED_HALF;
					MEDIA_HEAVY3:               speed = SPEED_THIRD;
					MEDIA_FILM, MEDIA_TRANSP:   speed = SPEED_TENTH;
					default:                    speed = SPEED_FULL;
				endcase
			end
			default:                    speed = SPEED_FULL;
		endcase
	end

	always_comb begin
		if (!job.duplex)
			mismatch = (job.mode == MODE_TRANSP && media != MEDIA_TRANSP)
				|| (job.mode != MODE_AUTO && job.mode != MODE_TRANSP && media == MEDIA_TRANSP);
		else
			mismatch = (job.mode != MODE_TRANSP && job.mode != MODE_GLOSSFILM
				&& media == MEDIA_TRANSP);
	end

endmodule

// ---- hw/paper_pickup_feed_sequencer.sv ----
// Manual-tray pickup and paper feed sequencer
`timescale 1ns/1ps
// Functional notes
// - Empty tray: notify, hold print
// - Print: reverse pickup motor, then solenoid
// - Last-sheet roller turns: notify formatter
// - Leading edge sensed: stop registration motor
// - Sample media sensor during pause
// - Alignment timing: restart registration motor
// - Derive and report paper type
// - Simplex transparency job, other media: mismatch
// - Simplex non-auto job, transparency sensed: mismatch
// - Duplex job, transparency sensed, mode neither MODE_TRANSP nor MODE_GLOSSFILM: mismatch
// - Power-up or wake: test sensor LED
// - Feed speed follows print mode
// - Unclassifiable media: speed from formatter mode
// - Output bin full: notify formatter
module paper_pickup_feed_sequencer
	import paper_feed_pkg::*;
#(
	parameter int REVERSE_CYCLES = REVERSE_CYC,
	parameter int SETTLE_CYCLES  = SENSE_SETTLE_CYC
)
(
	// Clock and reset
	input  wire logic       sys_clk,
	input  wire logic       arst_n,
	// Formatter
	input  wire logic       printCmd,
	input  wire job_t       job,
	input  wire logic       alignGo,
	input  wire logic       wakeUp,
	output notify_t         notify,
	output logic            busy,
	// Sensors, asynchronous pins
	input  wire logic       trayPaper,
	input  wire logic       lastSheetSense,
	input  wire logic       leadEdge,
	input  wire logic       fuserExit,
	input  wire logic       binFullSense,
	input  wire logic [7:0] reflect,
	input  wire logic [7:0] transmit,
	// Drives
	output drive_t          drive
);

	typedef struct packed {
		logic [2:0][4:0] sync;
		seq_state_t      state;
		logic [CNT_W-1:0] cnt;
		job_t            job;
		logic [7:0]      reflect;
		logic [7:0]      transmit;
		notify_t         notify;
		drive_t          drive;
		logic [4:0]      pinLvl;
		// Sensor words pass the same three-stage filter as the pins
		logic [2:0][7:0] reflSync;
		logic [2:0][7:0] transSync;
		logic [7:0]      reflLvl;
		logic [7:0]      transLvl;
	} state_t;

	state_t s;
	state_t next_s;

	media_t mediaNow;
	speed_t speedNow;
	logic   mismatchNow;

	// Pins clean: bit order tray, last, lead, exit, full
	logic [4:0] pinNow;
	logic [4:0] pinRaw;

	assign pinRaw = {trayPaper, lastSheetSense, leadEdge, fuserExit, binFullSense};

	// Filtered level: change counts once stages 2 and 3 agree
	function automatic logic filt(input logic a, input logic b, input logic prev);
		return (a == b) ? a : prev;
	endfunction

	// Whole-word agreement, so a capture torn across bits is never used
	function automatic logic [7:0] filtWord(input logic [7:0] a, input logic [7:0] b, input logic [7:0] prev);
		return (a == b) ? a : prev;
	endfunction

	// Tolerance band is symmetric about the expected LED level
	function automatic logic ledBad(input logic [7:0] v);
		return (v > LED_EXPECT + LED_TOL) || (v < LED_EXPECT - LED_TOL);
	endfunction

	logic [7:0] reflNow;
	logic [7:0] transNow;

	assign reflNow  = filtWord(s.reflSync[1], s.reflSync[2], s.reflLvl);
	assign transNow = filtWord(s.transSync[1], s.transSync[2], s.transLvl);

	media_classifier classify (
		.reflect  (s.reflect),
		.transmit (s.transmit),
		.job      (s.job),
		.media    (mediaNow),
		.speed    (speedNow),
		.mismatch (mismatchNow)
	);

	always_comb begin
		for (int i = 0; i < 5; i++)
			pinNow[i] = filt(s.sync[1][i], s.sync[2][i], s.pinLvl[i]);
	end

	always_comb begin
		next_s = s;
		next_s.sync[0] = pinRaw;
		next_s.sync[1] = s.sync[0];
		next_s.sync[2] = s.sync[1];
		next_s.pinLvl = pinNow;
		next_s.reflSync[0] = reflect;
		next_s.reflSync[1] = s.reflSync[0];
		next_s.reflSync[2] = s.reflSync[1];
		next_s.transSync[0] = transmit;
		next_s.transSync[1] = s.transSync[0];
		next_s.transSync[2] = s.transSync[1];
		next_s.reflLvl = reflNow;
		next_s.transLvl = transNow;
		next_s.notify.binFull = pinNow[0];
		next_s.notify.lastSheet = pinNow[3] && s.state != ST_IDLE;
		if (s.cnt != '0)
			next_s.cnt = s.cnt - 1'b1;
		case (s.state)
			ST_IDLE: begin
				next_s.drive.pickupRev = 1'b0;
				next_s.drive.pickupSol = 1'b0;
				if (wakeUp) begin
					next_s.state = ST_SELFTEST;
				end else if (printCmd) begin
					next_s.job = job;
					next_s.notify.typeValid = 1'b0;
					next_s.notify.mismatch = 1'b0;
					next_s.state = ST_WAITPAP;
				end
			end
			ST_WAITPAP: begin
				next_s.notify.trayEmpty = !pinNow[4];
				if (pinNow[4]) begin
					next_s.drive.pickupRev = 1'b1;
					next_s.cnt = CNT_W'(REVERSE_CYCLES);
					next_s.state = ST_REVERSE;
				end
			end
			ST_REVERSE: begin
				if (s.cnt == '0) begin
					next_s.drive.pickupSol = 1'b1;
					next_s.drive.regMotor = 1'b1;
					next_s.state = ST_PICK;
				end
			end
			ST_PICK, ST_FEED: begin
				if (pinNow[2]) begin
					next_s.drive.regMotor = 1'b0;
					next_s.drive.pickupSol = 1'b0;
					next_s.drive.pickupRev = 1'b0;
					next_s.drive.mediaLed = 1'b1;
					next_s.cnt = CNT_W'(SETTLE_CYCLES);
					next_s.state = ST_PAUSE;
				end
			end
			ST_PAUSE: begin
				// Sample once the LED has settled, keep last value while waiting
				if (s.cnt == '0 && !s.notify.typeValid) begin
					next_s.reflect = reflNow;
					next_s.transmit = transNow;
					next_s.notify.typeValid = 1'b1;
				end
				if (s.notify.typeValid) begin
					next_s.notify.mediaType = mediaNow;
					next_s.notify.mismatch = mismatchNow;
				end
				if (s.notify.typeValid && alignGo) begin
					next_s.drive.speed = speedNow;
					next_s.drive.regMotor = 1'b1;
					next_s.drive.mediaLed = 1'b0;
					next_s.state = ST_RUN;
				end
			end
			ST_RUN: begin
				// Speed stays frozen until the sheet clears the fuser
				if (pinNow[1]) begin
					next_s.drive.regMotor = 1'b0;
					next_s.drive.speed = SPEED_FULL;
					next_s.state = ST_IDLE;
				end
			end
			ST_SELFTEST: begin
				next_s.drive.mediaLed = 1'b1;
				next_s.cnt = CNT_W'(SETTLE_CYCLES);
				next_s.state = ST_TESTWAIT;
			end
			ST_TESTWAIT: begin
				if (s.cnt == '0) begin
					next_s.notify.sensorFail = ledBad(reflNow);
					next_s.drive.mediaLed = 1'b0;
					next_s.state = ST_IDLE;
				end
			end
			default: next_s.state = ST_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			s <= '0;
			s.state <= ST_SELFTEST;
		end else begin
			s <= next_s;
		end
	end

	assign notify = s.notify;
	assign drive  = s.drive;
	assign busy   = s.state != ST_IDLE;

endmodule

// ---- bench/paper_pickup_feed_sequencer_props.sv ----
// Assertions on the sequencer ports
`timescale 1ns/1ps
module feed_seq_props
	import paper_feed_pkg::*;
(
	// Clock and reset
	input wire logic    sys_clk,
	input wire logic    arst_n,
	// Inputs
	input wire logic    alignGo,
	input wire job_t    job,
	input wire logic    trayPaper,
	input wire logic    lastSheetSense,
	input wire logic    leadEdge,
	input wire logic    binFullSense,
	// Outputs
	input wire logic    busy,
	input wire notify_t notify,
	input wire drive_t  drive
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!arst_n);

	function automatic logic mm(job_t j, media_t m);
		if (j.duplex)
			return m == MEDIA_TRANSP && j.mode != MODE_TRANSP && j.mode != MODE_GLOSSFILM;
		return j.mode == MODE_TRANSP ? m != MEDIA_TRANSP : j.mode != MODE_AUTO && m == MEDIA_TRANSP;
	endfunction

	a_rev_then_sol: assert property
		($rose(drive.pickupSol) |-> $past(drive.pickupRev)) else $error("solenoid early");
	a_paper_first: assert property
		($rose(drive.pickupRev) |-> $past(trayPaper, 2)) else $error("pick on empty tray");
	a_edge_stops: assert property
		($rose(leadEdge) && drive.regMotor |-> ##[1:6] !drive.regMotor) else $error("motor not stopped");
	a_restart_cause: assert property
		($rose(drive.regMotor) && !drive.pickupSol |-> $past(alignGo) && $past(notify.typeValid))
		else $error("restart uncaused");
	a_speed_held: assert property
		(drive.regMotor && $past(drive.regMotor) |-> $stable(drive.speed)) else $error("speed moved");
	a_type_paused: assert property
		($rose(notify.typeValid) |-> !drive.regMotor && drive.mediaLed) else $error("type not in pause");
	a_mismatch_fn: assert property
		(notify.typeValid && $past(notify.typeValid) && drive.mediaLed |-> notify.mismatch == mm(job, notify.mediaType))
		else $error("mismatch wrong");
	a_bin_report: assert property
		(binFullSense [*6] |=> notify.binFull) else $error("bin full missed");
	a_last_report: assert property
		((busy && lastSheetSense) [*6] |=> notify.lastSheet) else $error("last sheet missed");
	c_restart: cover property ($rose(drive.regMotor) && !drive.pickupSol);
	c_mismatch: cover property (notify.mismatch);
	c_fail: cover property (notify.sensorFail);
endmodule
bind paper_pickup_feed_sequencer feed_seq_props chk_u (.sys_clk, .arst_n, .alignGo, .job, .trayPaper,
	.lastSheetSense, .leadEdge, .binFullSense, .busy, .notify, .drive);

// ---- bench/formatter_model.sv ----
// Formatter stand-in: print jobs and alignment strobes
`timescale 1ns/1ps
module formatter_model
	import paper_feed_pkg::*;
(
	// Clock and status
	input  wire logic sys_clk,
	input  wire logic busy,
	// Requests
	output logic      printCmd,
	output job_t      job,
	output logic      alignGo
);
	initial begin
		printCmd = 1'b0;
		job = job_t'(5'h00);
		alignGo = 1'b0;
	end
	// Held until taken or 20 cycles pass; job stays put for the whole sheet
	task automatic issue(job_t j);
		@(negedge sys_clk);
		job = j;
		printCmd = 1'b1;
		for (int k = 0; k < 20 && !busy; k++)
			@(negedge sys_clk);
		printCmd = 1'b0;
	endtask
	task automatic align();
		@(negedge sys_clk);
		alignGo = 1'b1;
		@(negedge sys_clk);
		alignGo = 1'b0;
	endtask
endmodule

// ---- bench/paper_pickup_feed_sequencer_tb_top.sv ----
// Bench for the pickup and feed sequencer
`timescale 1ns/1ps
module paper_pickup_feed_sequencer_tb_top;
	import paper_feed_pkg::*;
	logic        sys_clk = 1'b0;
	logic        arst_n = 1'b0;
	logic        wakeUp = 1'b0;
	logic        trayPaper = 1'b0;
	logic        lastSheetSense = 1'b0;
	logic        leadEdge = 1'b0;
	logic        fuserExit = 1'b0;
	logic        binFullSense = 1'b0;
	logic [7:0]  reflect = LED_EXPECT;
	logic [7:0]  transmit = LED_EXPECT;
	logic [31:0] seed = 32'h0324;
	int          failCount = 0;
	int          testsRun = 0;
	logic        printCmd;
	logic        alignGo;
	logic        busy;
	job_t        job;
	notify_t     notify;
	drive_t      drive;
	// Bit 16 busy, 10 typeValid, 6 reverse, 5 solenoid, 4 motor
	wire logic [16:0] obs = {busy, notify, drive};
	always #5 sys_clk = ~sys_clk;
	// Short counts keep each sheet brief
	paper_pickup_feed_sequencer #(.REVERSE_CYCLES(4), .SETTLE_CYCLES(3)) dut_u (.sys_clk, .arst_n, .printCmd, .job,
		.alignGo, .wakeUp, .notify, .busy, .trayPaper, .lastSheetSense, .leadEdge, .fuserExit, .binFullSense,
		.reflect, .transmit, .drive);
	formatter_model fmt_u (.sys_clk, .busy, .printCmd, .job, .alignGo);
	function automatic logic [31:0] lfsr(logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic media_t expMedia(logic [7:0] r, logic [7:0] t);
		if (r >= GLOSS_HIGH)
			return (t >= TRANS_CLEAR) ? MEDIA_TRANSP : MEDIA_FILM;
		if (r >= GLOSS_MID)
			return MEDIA_GLOSSY;
		if (t >= TRANS_HEAVY1)
			return MEDIA_PLAIN;
		if (t >= TRANS_HEAVY2)
			return MEDIA_HEAVY1;
		return (t >= TRANS_HEAVY3) ? MEDIA_HEAVY2 : MEDIA_HEAVY3;
	endfunction
	function automatic speed_t expSpeed(print_mode_t m, media_t k);
		case (m)
			MODE_HEAVY1, MODE_GLOSSY1: return SPEED_3Q;
			MODE_HEAVY2, MODE_GLOSSY2, MODE_LABEL: return SPEED_HALF;
			MODE_HEAVY3, MODE_GLOSSY3: return SPEED_THIRD;
			MODE_GLOSSFILM, MODE_TRANSP: return SPEED_TENTH;
			MODE_AUTO: begin
				case (k)
					MEDIA_HEAVY1, MEDIA_GLOSSY: return SPEED_3Q;
					MEDIA_HEAVY2: return SPEED_HALF;
					MEDIA_HEAVY3: return SPEED_THIRD;
					MEDIA_FILM, MEDIA_TRANSP: return SPEED_TENTH;
					default: return SPEED_FULL;
				endcase
			end
			default: return SPEED_FULL;
		endcase
	endfunction
	function automatic logic expMis(job_t j, media_t k);
		if (j.duplex)
			return k == MEDIA_TRANSP && j.mode != MODE_TRANSP && j.mode != MODE_GLOSSFILM;
		if (j.mode == MODE_TRANSP)
			return k != MEDIA_TRANSP;
		return j.mode != MODE_AUTO && k == MEDIA_TRANSP;
	endfunction
	task automatic chkBit(string n, logic e, logic g);
		testsRun++;
		if (g !== e) begin
			failCount++;
			$display("[ERR] %s expected %b seen %b", n, e, g);
		end
	endtask
	task automatic chkSpd(speed_t e, speed_t g);
		testsRun++;
		if (g !== e) begin
			failCount++;
			$display("[ERR] speed expected %0d seen %0d", e, g);
		end
	endtask
	task automatic chkMedia(media_t e, media_t g);
		testsRun++;
		if (g !== e) begin
			failCount++;
			$display("[ERR] media expected %0d seen %0d", e, g);
		end
	endtask
	task automatic giveVerdict();
		$display("checks %0d errors %0d", testsRun, failCount);
		if (failCount == 0 && testsRun > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic waitObs(int b, logic v);
		for (int k = 0; k < 40 && obs[b] !== v; k++)
			@(negedge sys_clk);
	endtask
	task automatic runJob(job_t j, logic [7:0] r, logic [7:0] t);
		waitObs(6, 1'b1);
		chkBit("solenoid early", 1'b0, drive.pickupSol);
		waitObs(5, 1'b1);
		chkBit("solenoid", 1'b1, drive.pickupSol);
		lastSheetSense = 1'b1;
		leadEdge = 1'b1;
		reflect = r;
		transmit = t;
		waitObs(4, 1'b0);
		chkBit("motor stop", 1'b0, drive.regMotor);
		// Strobe before the type is known must be ignored
		fmt_u.align();
		chkBit("early restart", 1'b0, drive.regMotor);
		waitObs(10, 1'b1);
		chkBit("type valid", 1'b1, notify.typeValid);
		chkBit("last sheet", 1'b1, notify.lastSheet);
		fmt_u.align();
		waitObs(4, 1'b1);
		chkBit("restart", 1'b1, drive.regMotor);
		chkSpd(expSpeed(j.mode, expMedia(r, t)), drive.speed);
		chkMedia(expMedia(r, t), notify.mediaType);
		chkBit("mismatch", expMis(j, expMedia(r, t)), notify.mismatch);
		leadEdge = 1'b0;
		lastSheetSense = 1'b0;
		fuserExit = 1'b1;
		waitObs(16, 1'b0);
		fuserExit = 1'b0;
		chkSpd(SPEED_FULL, drive.speed);
		chkBit("bin full", binFullSense, notify.binFull);
	endtask
	initial begin
		repeat (5) @(negedge sys_clk);
		arst_n = 1'b1;
		@(negedge sys_clk);
		waitObs(16, 1'b0);
		chkBit("sensor ok", 1'b0, notify.sensorFail);
		fmt_u.issue(job_t'({MODE_NORMAL, 1'b0}));
		repeat (10) @(negedge sys_clk);
		chkBit("tray empty", 1'b1, notify.trayEmpty);
		chkBit("held", 1'b0, drive.pickupRev);
		trayPaper = 1'b1;
		runJob(job_t'({MODE_NORMAL, 1'b0}), 8'h80, 8'h80);
		for (int i = 0; i < 13; i++) begin
			seed = lfsr(seed);
			binFullSense = seed[0];
			fmt_u.issue(job_t'({i[3:0], seed[1]}));
			runJob(job_t'({i[3:0], seed[1]}), seed[9:2], seed[17:10]);
		end
		fmt_u.issue(job_t'({MODE_TRANSP, 1'b0}));
		runJob(job_t'({MODE_TRANSP, 1'b0}), 8'h00, 8'h00);
		chkBit("mismatch", 1'b1, notify.mismatch);
		wakeUp = 1'b1;
		@(negedge sys_clk);
		wakeUp = 1'b0;
		@(negedge sys_clk);
		waitObs(16, 1'b0);
		chkBit("sensor fail", 1'b1, notify.sensorFail);
		giveVerdict();
	end
	// Planned traffic is well under a thousand cycles; ten thousand leaves ample margin
	initial begin
		repeat (10000) @(posedge sys_clk);
		failCount++;
		giveVerdict();
	end
endmodule
